// ---- include/cts_pkg.sv ----
// charger timer / thermal / status register slice: shared constants and types
// assumes a 32-bit AHB-Lite slave port, one register per aligned word
package cts_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  CTS_IDX_TIMER    = 8'h16;
  localparam logic [7:0]  CTS_IDX_THERMAL  = 8'h17;
  localparam logic [7:0]  CTS_IDX_HEALTH   = 8'h18;
  localparam logic [7:0]  CTS_IDX_INSTAT   = 8'h19;
  localparam logic [7:0]  CTS_IDX_NONE     = 8'hff;

  // reset values
  localparam logic [7:0]  CTS_TIMER_RST    = 8'h95;
  localparam logic [7:0]  CTS_THERMAL_RST  = 8'h24;
  localparam logic [7:0]  CTS_HEALTH_RST   = 8'h10;
  localparam logic [7:0]  CTS_INSTAT_RST   = 8'h00;

  // field positions
  localparam int          CTS_TMR_BIAS_BIT = 7;
  localparam int          CTS_TMR_DBL_BIT  = 6;
  localparam int          CTS_TMR_FAST_LSB = 4;
  localparam int          CTS_TMR_PREQ_LSB = 2;
  localparam int          CTS_TMR_TOP_LSB  = 0;
  localparam int          CTS_THM_BETA_LSB = 5;
  localparam int          CTS_THM_RSVD_LSB = 3;
  localparam int          CTS_THM_FOLD_LSB = 0;
  localparam int          CTS_INS_PWR_LSB  = 6;
  localparam int          CTS_INS_TREG_BIT = 4;

  // status codes
  localparam logic [1:0]  CTS_PWR_VALID    = 2'h3;
  localparam logic [2:0]  CTS_BAT_MISSING  = 3'h0;
  localparam logic [2:0]  CTS_BAT_DETECT   = 3'h1;
  localparam logic [2:0]  CTS_BAT_TOP_BAND = 3'h5;
  localparam logic [2:0]  CTS_BAT_IN_RESET = 3'h7;
  localparam logic [2:0]  CTS_ZONE_COLD    = 3'h1;
  localparam logic [2:0]  CTS_ZONE_HOT     = 3'h4;
  localparam logic [1:0]  CTS_SFTY_IDLE    = 2'h0;

  // durations: minutes, top-off in tenths of a minute
  localparam logic [10:0] CTS_FAST_BASE_MIN = 11'h0b4;  // 3 hr
  localparam logic [10:0] CTS_FAST_STEP_MIN = 11'h078;  // 2 hr
  localparam logic [6:0]  CTS_PREQ_STEP_MIN = 7'h0f;    // 15 min
  localparam logic [7:0]  CTS_TOP_STEP_DMIN = 8'h40;    // 6.4 min
  localparam logic [6:0]  CTS_FOLD_BASE_C   = 7'h50;    // 80 degC
  localparam logic [6:0]  CTS_FOLD_STEP_C   = 7'h05;

  // thermistor beta values (k) for codes 0..7
  localparam logic [12:0] CTS_BETA_TAB [8] = '{
    13'hd6a, 13'he1a, 13'hf5e, 13'hf6e, 13'h1004, 13'h10d7, 13'h11bf, 13'h128e};

  typedef struct packed {
    logic       bias_sel;
    logic       dbl;
    logic [1:0] fast;
    logic [1:0] preq;
    logic [1:0] topoff;
  } cts_timer_cfg_t;

  typedef struct packed {
    logic [2:0] beta;
    logic [1:0] rsvd;
    logic [2:0] fold;
  } cts_thermal_cfg_t;

  typedef struct packed {
    logic       present;
    logic       bat_valid;
    logic       pwr_good;
    logic       healthy;
    logic [3:0] rsvd;
  } cts_health_t;

  // raw charger state arriving from the analog side
  typedef struct packed {
    logic       attach;
    logic [2:0] bat_cond;
    logic [1:0] pwr_state;
    logic [2:0] zone;
    logic [1:0] sfty;
    logic       ilim;
    logic       over_temp;
    logic       cfg_lock;
  } cts_chg_state_t;

  // decoded settings for the charger loop
  typedef struct packed {
    logic [11:0] fast_min;
    logic [7:0]  preq_min;
    logic [7:0]  topoff_dmin;
    logic [12:0] beta_k;
    logic [6:0]  fold_degc;
    logic        bias_high;
  } cts_limits_t;

endpackage : cts_pkg

// ---- core/cts_decode.sv ----
// setting decoder: turns configuration codes into durations, beta and threshold
// assumes inputs come from registers on the same clock; purely combinational
`timescale 1ns/1ps
`default_nettype none
module cts_decode
  import cts_pkg::*;
(
  input  wire cts_pkg::cts_timer_cfg_t   timer,
  input  wire cts_pkg::cts_thermal_cfg_t thermal,
  output cts_pkg::cts_limits_t           limits
);
  logic [10:0] fast_base;
  logic [6:0]  preq_base;

  always_comb begin
    fast_base = CTS_FAST_BASE_MIN + 11'(CTS_FAST_STEP_MIN * timer.fast);
    preq_base = 7'(CTS_PREQ_STEP_MIN * (7'(timer.preq) + 7'h1));
    limits.fast_min    = timer.dbl ? {fast_base, 1'b0} : {1'b0, fast_base};
    limits.preq_min    = timer.dbl ? {preq_base, 1'b0} : {1'b0, preq_base};
    limits.topoff_dmin = 8'(CTS_TOP_STEP_DMIN * timer.topoff);
    limits.beta_k      = CTS_BETA_TAB[thermal.beta];
    limits.fold_degc   = CTS_FOLD_BASE_C + 7'(CTS_FOLD_STEP_C * thermal.fold);
    limits.bias_high   = timer.bias_sel;
  end
endmodule : cts_decode
`default_nettype wire

// ---- core/cts_regs.sv ----
// charger timer, thermal and status register slice behind an AHB-Lite slave
// assumes single word transfers, one slave on the bus, charger state from
// the analog side arriving asynchronously to hclk
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - timer/bias register is read/write; writes ignored while config lock is set
// - one-bit bias select, reset 1: 0 = 100k low current, 1 = 10k tenfold
// - double bit set doubles both pre-qualification and fast-charge timeouts
// - fast-charge code 00..11 gives 3, 5, 7, 9 hours; reset 01
// - pre-qualification code 00..11 gives 15, 30, 45, 60 minutes; reset 01
// - top-off code 00..11 gives 0, 6.4, 12.8, 19.2 minutes; reset 01
// - three-bit beta select in bits 7:5, reset 001, maps 3434k..4750k
// - three-bit fold threshold, reset 100, 80 degC plus 5 per step
// - status registers read-only; meaningful only while current limit inactive
// - health bit 7 is 1 when battery attachment detected, resets 0
// - battery-valid is 0 for codes 000 and 111, 1 for 001..101
// - input-power-good is 1 exactly when input power state is 11
// - healthy flag resets 1; cleared on zone 001/100 or timer state nonzero
// - health low four bits read 0; writes to health register do nothing
// - input power state: 00 undervoltage, 01 no headroom, 10 overvoltage, 11 good
// - battery code: 000 missing, 001 detecting, 010..101 bands, 111 reset
module cts_regs
  import cts_pkg::*;
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire cts_pkg::cts_chg_state_t chg_state,
  output cts_pkg::cts_timer_cfg_t      timer_cfg,
  output cts_pkg::cts_thermal_cfg_t    thermal_cfg,
  output cts_pkg::cts_limits_t         limits,
  output cts_pkg::cts_health_t         health,
  output logic      [7:0]              input_status,
  output logic                         status_valid
);

  import cts_pkg::*;

  typedef struct packed {
    cts_timer_cfg_t   timer;
    cts_thermal_cfg_t thermal;
    cts_health_t      health;
    logic [7:0]       instat;
    logic             stat_ok;
    cts_limits_t      limits;
    cts_chg_state_t   meta;
    cts_chg_state_t   chg;
    logic             dp_act;
    logic             dp_wr;
    logic [7:0]       dp_idx;
    logic [31:0]      rdata;
  } cts_state_t;

  cts_state_t  s_q;
  cts_state_t  s_d;
  cts_limits_t lim_w;

  // turn a bus address into a register index, or the unmapped marker
  function automatic logic [7:0] addr_index(input logic [31:0] a);
    logic [7:0] idx;
    idx = CTS_IDX_NONE;
    if (~|a[31:10] && (a[1:0] == 2'h0)) begin
      idx = a[9:2];
    end
    return idx;
  endfunction : addr_index

  function automatic cts_health_t health_of(input cts_chg_state_t c);
    cts_health_t h;
    h = '0;
    h.present   = c.attach;
    h.bat_valid = (c.bat_cond >= CTS_BAT_DETECT) &&
                  (c.bat_cond <= CTS_BAT_TOP_BAND);
    h.pwr_good  = (c.pwr_state == CTS_PWR_VALID);
    h.healthy   = !((c.zone == CTS_ZONE_COLD) ||
                    (c.zone == CTS_ZONE_HOT) ||
                    (c.sfty != CTS_SFTY_IDLE));
    h.rsvd      = 4'h0;
    return h;
  endfunction : health_of

  function automatic logic [7:0] instat_of(input cts_chg_state_t c);
    logic [7:0] v;
    v = '0;
    v[CTS_INS_PWR_LSB +: 2] = c.pwr_state;
    v[CTS_INS_TREG_BIT]     = c.over_temp;
    return v;
  endfunction : instat_of

  // read path sees the values that will stand during the data phase
  function automatic logic [31:0] read_word(input logic [7:0] idx,
                                            input cts_state_t s);
    logic [31:0] w;
    w = '0;
    unique case (idx)
      CTS_IDX_TIMER: begin
        w[7:0] = s.timer;
      end
      CTS_IDX_THERMAL: begin
        w[7:0] = s.thermal;
      end
      CTS_IDX_HEALTH: begin
        w[7:0] = s.health;
      end
      CTS_IDX_INSTAT: begin
        w[7:0] = s.instat;
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction : read_word

  cts_decode u_decode (
    .timer   (s_q.timer),
    .thermal (s_q.thermal),
    .limits  (lim_w)
  );

  always_comb begin
    s_d = s_q;

    // two-stage sync of the analog charger state
    s_d.meta = chg_state;
    s_d.chg  = s_q.meta;

    // data phase of a write accepted last cycle
    if (s_q.dp_act && s_q.dp_wr) begin
      unique case (s_q.dp_idx)
        CTS_IDX_TIMER: begin
          if (!s_q.chg.cfg_lock) begin
            s_d.timer = cts_timer_cfg_t'(hwdata[7:0]);
          end
        end
        CTS_IDX_THERMAL: begin
          s_d.thermal = cts_thermal_cfg_t'(hwdata[7:0]);
        end
        default: begin
          s_d.dp_wr = 1'b0;
        end
      endcase
    end

    // status follows the synchronised charger state
    s_d.health  = health_of(s_q.chg);
    s_d.instat  = instat_of(s_q.chg);
    s_d.stat_ok = !s_q.chg.ilim;
    s_d.limits  = lim_w;

    // address phase
    s_d.dp_act = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.dp_act = 1'b1;
      s_d.dp_wr  = hwrite;
      s_d.dp_idx = addr_index(haddr);
      if (!hwrite) begin
        s_d.rdata = read_word(s_d.dp_idx, s_d);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q         <= '0;
      s_q.timer   <= cts_timer_cfg_t'(CTS_TIMER_RST);
      s_q.thermal <= cts_thermal_cfg_t'(CTS_THERMAL_RST);
      s_q.health  <= cts_health_t'(CTS_HEALTH_RST);
      s_q.instat  <= CTS_INSTAT_RST;
      s_q.dp_idx  <= CTS_IDX_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // zero wait states, always OKAY
  logic hreadyout_q;
  logic [31:0] hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_comb begin
    hrdata_q = s_q.rdata;
  end

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = 1'b0;
  assign timer_cfg    = s_q.timer;
  assign thermal_cfg  = s_q.thermal;
  assign limits       = s_q.limits;
  assign health       = s_q.health;
  assign input_status = s_q.instat;
  assign status_valid = s_q.stat_ok;

endmodule : cts_regs
`default_nettype wire

// ---- sim/cts_regs_sva.sv ----
// checker for the charger register slice: decode, hold and read-path properties
// assumes it is bound to cts_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module cts_regs_sva
  import cts_pkg::*;
(
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic                      hsel,
  input wire logic [31:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic [2:0]                hsize,
  input wire logic [31:0]               hwdata,
  input wire logic                      hready,
  input wire logic [31:0]               hrdata,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire cts_pkg::cts_chg_state_t   chg_state,
  input wire cts_pkg::cts_timer_cfg_t   timer_cfg,
  input wire cts_pkg::cts_thermal_cfg_t thermal_cfg,
  input wire cts_pkg::cts_limits_t      limits,
  input wire cts_pkg::cts_health_t      health,
  input wire logic [7:0]                input_status,
  input wire logic                      status_valid
);
  import cts_pkg::*;
  logic tw;
  assign tw = hsel && hready && htrans[1] && hwrite && haddr == 32'h58;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_s;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  ready_okay_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("slave not ready or not okay");
  fast_dec_a: assert property ($past(hresetn) |-> limits.fast_min ==
    (({10'h0, $past(timer_cfg.fast)} * 12'h078 + 12'h0b4) << $past(timer_cfg.dbl)))
    else $error("fast timeout decode wrong");
  preq_dec_a: assert property ($past(hresetn) |-> limits.preq_min ==
    (({6'h0, $past(timer_cfg.preq)} + 8'h01) * 8'h0f << $past(timer_cfg.dbl)))
    else $error("precharge timeout decode wrong");
  topoff_dec_a: assert property ($past(hresetn) |->
    limits.topoff_dmin == {$past(timer_cfg.topoff), 6'h0}) else $error("topoff decode wrong");
  fold_dec_a: assert property ($past(hresetn) |-> limits.fold_degc ==
    7'h50 + 7'h05 * {4'h0, $past(thermal_cfg.fold)}) else $error("fold decode wrong");
  beta_bias_a: assert property ($past(hresetn) |->
    limits.beta_k == CTS_BETA_TAB[$past(thermal_cfg.beta)] &&
    limits.bias_high == $past(timer_cfg.bias_sel)) else $error("beta or bias wrong");
  timer_hold_a: assert property ($changed(timer_cfg) |-> $past(tw, 2))
    else $error("timer config changed without a write");
  timer_rd_a: assert property (rd_s ##0 haddr == 32'h58 |=>
    hrdata == {24'h0, timer_cfg}) else $error("timer read data wrong");
  health_rd_a: assert property (rd_s ##0 haddr == 32'h60 |=>
    hrdata == {24'h0, health} && hrdata[3:0] == 4'h0) else $error("health read wrong");
  unmapped_rd_a: assert property (rd_s ##0 haddr[9:2] > 8'h19 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : cts_regs_sva
bind cts_regs cts_regs_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chg_state(chg_state),
  .timer_cfg(timer_cfg), .thermal_cfg(thermal_cfg), .limits(limits), .health(health),
  .input_status(input_status), .status_valid(status_valid));
`default_nettype wire

// ---- sim/cts_regs_test.sv ----
// self-checking bench for the charger register slice over AHB-Lite
// assumes cts_pkg and cts_regs compiled first; the checker binds itself
`timescale 1ns/1ps
`default_nettype none
module cts_regs_test;
  import cts_pkg::*;
  logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
  logic [1:0]       htrans = 2'h0;
  logic [2:0]       hsize = 3'h2;
  logic             hreadyout, hresp, status_valid;
  logic [7:0]       input_status, d;
  cts_chg_state_t   chg_state = '0;
  cts_timer_cfg_t   timer_cfg;
  cts_thermal_cfg_t thermal_cfg;
  cts_limits_t      limits;
  cts_health_t      health;
  int               miscompares = 0, check_count = 0;
  logic [7:0]       tv [4] = '{8'h00, 8'hff, 8'h6a, 8'h15};
  logic [31:0]      fe [4] = '{32'h0b4, 32'h438, 32'h348, 32'h12c};
  assign hready = hreadyout;
  cts_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chg_state(chg_state), .timer_cfg(timer_cfg),
    .thermal_cfg(thermal_cfg), .limits(limits), .health(health), .input_status(input_status),
    .status_valid(status_valid));
  initial begin
    forever #4 hclk = ~hclk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask : xfer
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string name);
    xfer(1'b0, a, 32'h0);
    cmp(name, exp, rdata);
  endtask : rdchk
  // run is a few hundred cycles; cut off far beyond that
  initial begin
    #200000;
    miscompares++;
    results();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    rdchk(32'h58, 32'h95, "timer reset");
    rdchk(32'h5c, 32'h24, "thermal reset");
    rdchk(32'h60, 32'h10, "health reset");
    rdchk(32'h64, 32'h00, "input status reset");
    foreach (tv[i]) begin
      xfer(1'b1, 32'h58, {24'h0, tv[i]});
      rdchk(32'h58, {24'h0, tv[i]}, "timer");
      cmp("fast timeout", fe[i], {20'h0, limits.fast_min});
      cmp("timer port", {24'h0, tv[i]}, {24'h0, timer_cfg});
    end
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], i[1:0], ~i[2:0]};
      xfer(1'b1, 32'h5c, {24'h0, d});
      rdchk(32'h5c, {24'h0, d}, "thermal");
      cmp("thermal port", {24'h0, d}, {24'h0, thermal_cfg});
      cmp("fold", 32'(80 + 5 * (7 - i)), {25'h0, limits.fold_degc});
      cmp("beta", {19'h0, CTS_BETA_TAB[i]}, {19'h0, limits.beta_k});
    end
    chg_state.cfg_lock <= 1'b1;
    repeat (4) @(posedge hclk);
    xfer(1'b1, 32'h58, 32'h0);
    rdchk(32'h58, 32'h15, "locked timer");
    xfer(1'b1, 32'h5c, 32'h24);
    rdchk(32'h5c, 32'h24, "thermal under lock");
    chg_state.cfg_lock <= 1'b0;
    xfer(1'b1, 32'h60, 32'hff);
    xfer(1'b1, 32'h64, 32'hff);
    xfer(1'b1, 32'h7c, 32'hff);
    rdchk(32'h60, 32'h10, "health after write");
    rdchk(32'h64, 32'h00, "input status after write");
    rdchk(32'h7c, 32'h00, "unmapped");
    // one status combination per pass; code 110 avoided
    for (int i = 0; i < 8; i++) begin
      chg_state <= '{attach: i[0], bat_cond: (i == 6) ? 3'h7 : i[2:0], pwr_state: i[1:0],
                     zone: i[2:0], sfty: {1'b0, i == 6}, ilim: i[2], over_temp: i[1],
                     cfg_lock: 1'b0};
      repeat (5) @(posedge hclk);
      d = {i[0], i >= 1 && i <= 5, i[1:0] == 2'h3, !(i == 1 || i == 4 || i == 6), 4'h0};
      rdchk(32'h60, {24'h0, d}, "health");
      rdchk(32'h64, {24'h0, i[1:0], 1'b0, i[1], 4'h0}, "input status");
      cmp("status valid", {31'h0, ~i[2]}, {31'h0, status_valid});
      cmp("health port", {24'h0, d}, {24'h0, health});
      cmp("input port", {24'h0, i[1:0], 1'b0, i[1], 4'h0}, {24'h0, input_status});
    end
    results();
  end
endmodule : cts_regs_test
`default_nettype wire
